// File: core/stlc_pkg.sv
/*
 * Package for the transmitter lane control zero register bank: offsets, field
 * positions, reset values, lane selection codes and the per-lane carrier type.
 * Assumes a 32-bit APB slave with one aligned word per register.
 */
package stlc_pkg;
	localparam int          STLC_LANES          = 4;
	localparam logic [11:0] STLC_OFF_TXLC0      = 12'h000;
	localparam logic [11:0] STLC_OFF_LANE_TARGET_SELECT    = 12'h004;
	localparam logic [11:0] STLC_OFF_LANE0      = 12'h010;
	localparam logic [4:0]  STLC_SEL_RESET      = 5'h10;
	localparam logic [4:0]  STLC_SEL_ALL        = 5'h10;
	localparam logic [4:0]  STLC_SEL_MAX_SINGLE = 5'h03;
	localparam int          STLC_FDG1_LSB       = 0;
	localparam int          STLC_FDG2L_LSB      = 2;
	localparam int          STLC_FDG2H_LSB      = 4;
	localparam int          STLC_SLEW1_LSB      = 18;
	localparam int          STLC_SLEW2_LSB      = 23;
	localparam int          STLC_BOOST_LSB      = 27;
	localparam logic [1:0]  STLC_FDG1_RST       = 2'h2;
	localparam logic [1:0]  STLC_FDG2L_RST      = 2'h3;
	localparam logic [1:0]  STLC_FDG2H_RST      = 2'h2;
	localparam logic [2:0]  STLC_SLEW1_RST      = 3'h1;
	localparam logic [2:0]  STLC_SLEW2_RST      = 3'h0;
	localparam logic [1:0]  STLC_BOOST_RST      = 2'h0;

	typedef struct packed {
		logic [1:0] fine_deemph_gen1;
		logic [1:0] fine_deemph_gen2_low_level;
		logic [1:0] fine_deemph_gen2_high_level;
		logic [2:0] driver_slew_gen1;
		logic [2:0] driver_slew_gen2;
		logic [1:0] driver_swing_boost;
	} stlc_lane_t;

	localparam stlc_lane_t STLC_LANE_RST = '{STLC_FDG1_RST, STLC_FDG2L_RST,
		STLC_FDG2H_RST, STLC_SLEW1_RST, STLC_SLEW2_RST, STLC_BOOST_RST};
endpackage

// File: core/stlc_regs.sv
/*
 * Transmitter lane control zero register bank with per-lane storage, APB slave.
 * Assumes presetn is the fundamental reset; software resets never reach it.
 */
// Implementation choices: the placing of the registers and the APB interface to the registers.
// How it works
// - fine_deemph_gen1 sits in bits 1:0, resets to 2, for full swing at 2.5 GT/s.
// - fine_deemph_gen2_low_level sits in bits 3:2, resets to 3, used at -3.5dB.
// - fine_deemph_gen2_high_level sits in bits 5:4, resets to 2, used at -6.0dB.
// - all fine de-emphasis codes are forced off toward the driver in low swing.
// - a write lands only in the lane or lanes the lane target select names.
// - per-lane values survive software resets, selected or not.
// - driver_slew_gen1 sits in bits 20:18, resets to 1 (0 is 58 ps, 1 is 98 ps).
// - driver_slew_gen2 sits in bits 25:23, resets to 0 with the same encoding.
// - driver_swing_boost sits in bits 28:27, resets to 0, code 1 is about 5% more.
// - select codes 0 to 3 name one lane, code 0x10 names all lanes.
// - a read returns the last value written whatever the lane selection.
`timescale 1ns/100ps
module stlc_regs
	import stlc_pkg::*;
(
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [11:0]                   paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic                          low_swing_mode,
	output stlc_lane_t [STLC_LANES-1:0]        lane_cfg
);
	logic [4:0]              lane_target_select;
	stlc_lane_t              last_written;
	stlc_lane_t [STLC_LANES-1:0] lane_store;
	logic                    wr_en;
	logic                    rd_en;
	logic                    hit;
	stlc_lane_t              wr_fields;
	logic [31:0]             next_prdata;

	assign pready  = 1'b1;
	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = psel & ~penable & ~pwrite;

	always_comb
	begin
		wr_fields.fine_deemph_gen1            = pwdata[STLC_FDG1_LSB +: 2];
		wr_fields.fine_deemph_gen2_low_level  = pwdata[STLC_FDG2L_LSB +: 2];
		wr_fields.fine_deemph_gen2_high_level = pwdata[STLC_FDG2H_LSB +: 2];
		wr_fields.driver_slew_gen1            = pwdata[STLC_SLEW1_LSB +: 3];
		wr_fields.driver_slew_gen2            = pwdata[STLC_SLEW2_LSB +: 3];
		wr_fields.driver_swing_boost          = pwdata[STLC_BOOST_LSB +: 2];
	end

	always_comb
	begin
		hit = (paddr == STLC_OFF_TXLC0) || (paddr == STLC_OFF_LANE_TARGET_SELECT);
		for (int i = 0; i < STLC_LANES; i++)
			if (paddr == STLC_OFF_LANE0 + 12'(4 * i))
				hit = 1'b1;
	end

	// unmapped addresses answer with an error, no side effect
	assign pslverr = psel & penable & ~hit;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			lane_target_select <= STLC_SEL_RESET;
		else if (wr_en && paddr == STLC_OFF_LANE_TARGET_SELECT)
			lane_target_select <= pwdata[4:0];
	end

	// shadow of the last write, so reads ignore lane selection
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			last_written <= STLC_LANE_RST;
		else if (wr_en && paddr == STLC_OFF_TXLC0)
			last_written <= wr_fields;
	end

	genvar g;
	generate
		for (g = 0; g < STLC_LANES; g++)
		begin : g_lane
			// only presetn clears these; no soft reset input exists
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					lane_store[g] <= STLC_LANE_RST;
				else if (wr_en && paddr == STLC_OFF_TXLC0 &&
					(lane_target_select == STLC_SEL_ALL ||
					 lane_target_select == 5'(g)))
					lane_store[g] <= wr_fields;
			end

			always_comb
			begin
				lane_cfg[g] = lane_store[g];
				if (low_swing_mode)
				begin
					// de-emphasis is off in low swing, codes are masked
					lane_cfg[g].fine_deemph_gen1            = 2'h0;
					lane_cfg[g].fine_deemph_gen2_low_level  = 2'h0;
					lane_cfg[g].fine_deemph_gen2_high_level = 2'h0;
				end
			end
		end
	endgenerate

	always_comb
	begin
		next_prdata = 32'h0;
		case (paddr)
			STLC_OFF_TXLC0:
			begin
				next_prdata[STLC_FDG1_LSB +: 2]  = last_written.fine_deemph_gen1;
				next_prdata[STLC_FDG2L_LSB +: 2] = last_written.fine_deemph_gen2_low_level;
				next_prdata[STLC_FDG2H_LSB +: 2] = last_written.fine_deemph_gen2_high_level;
				next_prdata[STLC_SLEW1_LSB +: 3] = last_written.driver_slew_gen1;
				next_prdata[STLC_SLEW2_LSB +: 3] = last_written.driver_slew_gen2;
				next_prdata[STLC_BOOST_LSB +: 2] = last_written.driver_swing_boost;
			end
			STLC_OFF_LANE_TARGET_SELECT:
				next_prdata[4:0] = lane_target_select;
			default:
			begin
				for (int i = 0; i < STLC_LANES; i++)
					if (paddr == STLC_OFF_LANE0 + 12'(4 * i))
						next_prdata[STLC_FDG1_LSB +: 14] = {lane_store[i].fine_deemph_gen1,
							2'h0, 10'h0};
			end
		endcase
	end

	// lane read-back: only the fine gen1 code is reported, in bits 13:12; all other bits read 0
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0;
		else if (rd_en)
			prdata <= next_prdata;
	end
endmodule

// File: dv/stlc_regs_monitor.sv
/* port checker for stlc_regs; bound from the bench top, one clock domain */
`timescale 1ns/100ps
module stlc_regs_monitor
	import stlc_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        low_swing_mode,
	input wire stlc_lane_t [STLC_LANES-1:0] lane_cfg
);
	logic [4:0]  sel;
	logic [31:0] shw;
	logic [13:0] wl;
	logic        wr;
	logic        rd;
	assign wr = psel && penable && pwrite && paddr == 12'h000;
	assign rd = psel && penable && !pwrite && paddr == 12'h000;
	assign wl = {pwdata[1:0], pwdata[3:2], pwdata[5:4], pwdata[20:18], pwdata[25:23], pwdata[28:27]};
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			sel <= 5'h10;
		else if (psel && penable && pwrite && paddr == 12'h004)
			sel <= pwdata[4:0];
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			shw <= 32'h0004002E;
		else if (wr)
			shw <= pwdata & 32'h1B9C003F;
	property p_lsw; low_swing_mode |-> (lane_cfg & {STLC_LANES{14'h3F00}}) == 0; endproperty
	a_lsw: assert property (p_lsw) else $error("fine codes live in low swing");
	property p_rsv; rd |-> (prdata & 32'hE463FFC0) == 0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
	property p_rd; rd |-> prdata == shw; endproperty
	a_rd: assert property (p_rd) else $error("read not last written");
	property p_hold; !wr ##1 $stable(low_swing_mode) |-> $stable(lane_cfg); endproperty
	a_hold: assert property (p_hold) else $error("lane value moved");
	property p_rst; $rose(presetn) && !low_swing_mode |-> lane_cfg == {STLC_LANES{STLC_LANE_RST}}; endproperty
	a_rst: assert property (p_rst) else $error("lane defaults wrong");
	property p_one; wr && sel == 5'h00 ##1 $stable(low_swing_mode) |-> $stable(lane_cfg[3:1]); endproperty
	a_one: assert property (p_one) else $error("unselected lane written");
	property p_rsel; wr && sel > 5'h03 && sel != 5'h10 ##1 $stable(low_swing_mode) |-> $stable(lane_cfg); endproperty
	a_rsel: assert property (p_rsel) else $error("reserved select wrote");
	property p_all; wr && sel == 5'h10 ##1 !low_swing_mode |-> lane_cfg == {STLC_LANES{$past(wl)}}; endproperty
	a_all: assert property (p_all) else $error("broadcast write wrong");
endmodule

// File: dv/stlc_regs_test.sv
/* self-checking bench for stlc_regs; drives APB and low swing itself */
`timescale 1ns/100ps
module stlc_regs_test
	import stlc_pkg::*;
;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, low_swing_mode = 0, pready, pslverr;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r = 32'h80DA, sh;
	logic [4:0]  sel;
	logic [32:0] q[$];
	stlc_lane_t [STLC_LANES-1:0] lane_cfg, ex;
	int miscompares = 0, checked = 0, cyc = 0;
	stlc_regs dut_u(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.low_swing_mode(low_swing_mode), .lane_cfg(lane_cfg));
	always #12.5 pclk = ~pclk;
	function logic [31:0] lf(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task chk(input logic [63:0] s, input logic [63:0] e);
		checked++;
		if (s !== e)
		begin
			miscompares++;
			$display("mismatch at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task final_report;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w)
			q.push_back(e);
		@(posedge pclk);
		penable <= 1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
		@(negedge pclk);
	endtask
	task wr(input logic [31:0] d);
		sh = d & 32'h1B9C003F;
		for (int i = 0; i < STLC_LANES; i++)
			if (sel == i || sel == STLC_SEL_ALL)
				ex[i] = {d[1:0], d[3:2], d[5:4], d[20:18], d[25:23], d[28:27]};
		apb(1, STLC_OFF_TXLC0, d, 0);
	endtask
	// reads are judged here, in order of issue
	always @(posedge pclk)
	begin
		cyc++;
		if (psel && penable && !pwrite)
			chk({pslverr, prdata}, q.pop_front());
		if (cyc > 3000)
		begin
			miscompares++;
			final_report;
		end
	end
	initial
	begin
		repeat (2)
		begin
			ex = {STLC_LANES{STLC_LANE_RST}};
			sh = 32'h0004002E;
			sel = STLC_SEL_RESET;
			@(posedge pclk);
			presetn <= 0;
			repeat (3) @(posedge pclk);
			presetn <= 1;
			apb(0, STLC_OFF_TXLC0, 0, {1'b0, sh});
			apb(0, STLC_OFF_LANE_TARGET_SELECT, 0, 33'h10);
			chk(lane_cfg, ex);
			// code 4 is reserved: stored word changes, no lane does
			for (int i = 0; i < 6; i++)
			begin
				sel = (i == 5) ? STLC_SEL_ALL : 5'(i);
				apb(1, STLC_OFF_LANE_TARGET_SELECT, {27'h0, sel}, 0);
				r = lf(r);
				wr(r);
				apb(0, STLC_OFF_TXLC0, 0, {1'b0, sh});
				chk(lane_cfg, ex);
			end
			// debug word of each lane carries its gen 1 fine code in bits 13:12
			for (int i = 0; i < STLC_LANES; i++)
				apb(0, STLC_OFF_LANE0 + 12'(4 * i), 0, {19'h0, ex[i].fine_deemph_gen1, 12'h0});
			wr(32'h0004002E);
			apb(0, STLC_OFF_TXLC0, 0, {1'b0, sh});
			@(posedge pclk);
			low_swing_mode <= 1;
			wr(32'h0000003F);
			chk(lane_cfg, ex & {STLC_LANES{14'h00FF}});
			@(posedge pclk);
			low_swing_mode <= 0;
			apb(1, 12'hFF0, 32'hFFFFFFFF, 0);
			apb(0, 12'hFFC, 0, 33'h100000000);
			apb(0, STLC_OFF_TXLC0, 0, {1'b0, sh});
			chk(lane_cfg, ex);
			$display("lane test pass done");
		end
		final_report;
	end
endmodule
bind stlc_regs stlc_regs_monitor mon_u(.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .low_swing_mode(low_swing_mode), .lane_cfg(lane_cfg));
